// ===== inc/smcp_pkg.sv
package smcp_pkg;

  // Array geometry
  localparam int ADDR_W = 11;
  localparam int MEM_WORDS = 2048;
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] ADDR_HI_W = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 11'h7ff;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;

  // Op-codes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;

  // Status byte field positions
  localparam int ST_PIN_PROTECT = 7;
  localparam int ST_BLOCK_HI = 3;
  localparam int ST_BLOCK_LO = 2;
  localparam int ST_LATCH = 1;

  // Block protect codes and range bases
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [ADDR_W-1:0] PROT_QUARTER_BASE = 11'h600;
  localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 11'h400;

  // Factory value of {pin_protect_enable, block_protect_hi, _lo}
  localparam logic [2:0] NV_INIT = 3'h0;

  typedef enum logic [6:0] {
    PH_OPCODE  = 7'h01,
    PH_ADDR_HI = 7'h02,
    PH_ADDR_LO = 7'h04,
    PH_RDATA   = 7'h08,
    PH_WDATA   = 7'h10,
    PH_STATUS  = 7'h20,
    PH_IGNORE  = 7'h40
  } smcp_phase_t;

endpackage

// ===== design/smcp_command_port.sv
`timescale 1ns/1ps
// Contract
// - Modes 0 and 3, mode taken at select
// - Sample input rising, drive output falling
// - Byte groups, most significant bit first
// - First byte after select is op-code
// - One op-code per chip select
// - Decode set-latch and clear-latch op-codes
// - Decode status read and status write
// - Decode memory read and memory write
// - Latch commands carry no further bytes
// - Latch cleared at power-up
// - Set-latch sets latch, shown status bit 1
// - Status write clears latch flag when frame ends
// - Latch clears when write ends
// - Clear-latch command resets latch
// - Status read returns one status byte
// - Status write loads writable status bits
// - Status layout; fixed zero bits
// - Protect bits kept in nonvolatile storage
// - Block protect ranges refuse array writes
// - Pin protect gates status writes
// - Protect pin never blocks array writes
// - Lines watched only while selected
// - Two-byte address, low 11 bits used
// - Address increments and wraps to zero
// - Byte committed at its eighth bit
// - Output driven only during array read data and status read data
module smcp_command_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so_o,
  output logic so_oe_n,
  output logic [7:0] status_view,
  output logic link_busy,
  output logic link_mode3
);

  typedef struct packed {
    logic seen_tgl;
    smcp_pkg::smcp_phase_t phase;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [smcp_pkg::ADDR_W-1:0] addr;
    logic wr_op;
    logic write_latch_flag;
    logic wr_armed;
    logic [1:0] wp_sync;
  } smcp_link_t;

  typedef struct packed {
    logic [1:0] wp_sync;
    logic [7:0] view_m;
    logic [7:0] view_s;
    logic [1:0] busy_sync;
    logic [1:0] mode_sync;
  } smcp_sys_t;

  smcp_link_t lk;
  smcp_link_t next_lk;
  smcp_sys_t sy;
  smcp_sys_t next_sy;

  logic cs_tgl;
  logic mode3;
  logic so_q;
  logic so_en_q;
  // Protect bits survive nrst like the array; factory value for simulation
  logic [2:0] nv_bits = smcp_pkg::NV_INIT;
  logic [7:0] mem [smcp_pkg::MEM_WORDS];

  logic new_tx;
  smcp_pkg::smcp_phase_t ph;
  logic [2:0] bc;
  logic wel_now;
  logic [7:0] byte_in;
  logic byte_done;
  logic mem_we;
  logic nv_we;
  logic addr_prot;
  logic [7:0] status_byte;
  logic [smcp_pkg::ADDR_W-1:0] addr_inc;

  // Select edge: new transaction marker and clock level at that moment
  always_ff @(negedge cs_n or negedge nrst) begin
    if (!nrst) begin
      cs_tgl <= 1'b0;
      mode3 <= 1'b0;
    end else begin
      cs_tgl <= ~cs_tgl;
      mode3 <= sck;
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[smcp_pkg::ST_PIN_PROTECT] = nv_bits[2];
    status_byte[smcp_pkg::ST_BLOCK_HI] = nv_bits[1];
    status_byte[smcp_pkg::ST_BLOCK_LO] = nv_bits[0];
    status_byte[smcp_pkg::ST_LATCH] = wel_now;
  end

  always_comb begin
    case (nv_bits[1:0])
      smcp_pkg::BP_QUARTER: addr_prot = lk.addr >= smcp_pkg::PROT_QUARTER_BASE;
      smcp_pkg::BP_HALF: addr_prot = lk.addr >= smcp_pkg::PROT_HALF_BASE;
      smcp_pkg::BP_ALL: addr_prot = 1'b1;
      default: addr_prot = 1'b0;
    endcase
  end

  assign addr_inc = lk.addr + smcp_pkg::ADDR_ONE;

  always_comb begin
    next_lk = lk;
    mem_we = 1'b0;
    nv_we = 1'b0;
    // A changed select toggle means this is the first rise of a frame
    new_tx = lk.seen_tgl != cs_tgl;
    ph = lk.phase;
    bc = lk.cnt;
    wel_now = lk.write_latch_flag & ~lk.wr_armed;
    next_lk.wp_sync = {lk.wp_sync[0], sy.wp_sync[1]};
    if (new_tx) begin
      next_lk.seen_tgl = cs_tgl;
      ph = smcp_pkg::PH_OPCODE;
      bc = 3'h0;
      next_lk.wr_op = 1'b0;
      // Latch clear of the last frame's write, deferred to here
      next_lk.write_latch_flag = wel_now;
      next_lk.wr_armed = 1'b0;
    end
    wel_now = next_lk.write_latch_flag;
    byte_in = {(new_tx ? 7'h00 : lk.sh[6:0]), si};
    // Stray clocks while deselected commit nothing
    byte_done = (bc == smcp_pkg::BIT_LAST) & ~cs_n;
    next_lk.sh = byte_in;
    next_lk.cnt = bc + 3'h1;
    next_lk.tx = {lk.tx[6:0], 1'b0};
    next_lk.phase = ph;
    case (ph)
      smcp_pkg::PH_OPCODE: begin
        if (byte_done) begin
          next_lk.phase = smcp_pkg::PH_IGNORE;
          case (byte_in)
            smcp_pkg::OP_SET_LATCH: next_lk.write_latch_flag = 1'b1;
            smcp_pkg::OP_CLR_LATCH: next_lk.write_latch_flag = 1'b0;
            smcp_pkg::OP_STATUS_READ: begin
              next_lk.tx = status_byte;
              next_lk.phase = smcp_pkg::PH_STATUS;
            end
            smcp_pkg::OP_STATUS_WRITE: begin
              next_lk.wr_armed = 1'b1;
              next_lk.wr_op = 1'b1;
              next_lk.phase = smcp_pkg::PH_STATUS;
            end
            smcp_pkg::OP_MEM_READ: begin
              next_lk.phase = smcp_pkg::PH_ADDR_HI;
            end
            smcp_pkg::OP_MEM_WRITE: begin
              next_lk.wr_armed = 1'b1;
              next_lk.wr_op = 1'b1;
              next_lk.phase = smcp_pkg::PH_ADDR_HI;
            end
            default: next_lk.phase = smcp_pkg::PH_IGNORE;
          endcase
        end
      end
      smcp_pkg::PH_ADDR_HI: begin
        if (byte_done) begin
          // Upper five address bits are don't care
          next_lk.addr[10:8] = byte_in[2:0];
          next_lk.phase = smcp_pkg::PH_ADDR_LO;
        end
      end
      smcp_pkg::PH_ADDR_LO: begin
        if (byte_done) begin
          next_lk.addr[7:0] = byte_in;
          if (lk.wr_op) begin
            next_lk.phase = smcp_pkg::PH_WDATA;
          end else begin
            next_lk.phase = smcp_pkg::PH_RDATA;
            next_lk.tx = mem[{lk.addr[10:8], byte_in}];
          end
        end
      end
      smcp_pkg::PH_RDATA: begin
        if (byte_done) begin
          next_lk.addr = addr_inc;
          next_lk.tx = mem[addr_inc];
        end
      end
      smcp_pkg::PH_WDATA: begin
        if (byte_done) begin
          mem_we = wel_now & ~addr_prot;
          next_lk.addr = addr_inc;
        end
      end
      smcp_pkg::PH_STATUS: begin
        if (byte_done) begin
          // Pin only matters with pin protect set
          nv_we = lk.wr_op & wel_now & ~(nv_bits[2] & ~lk.wp_sync[1]);
          next_lk.phase = smcp_pkg::PH_IGNORE;
        end
      end
      smcp_pkg::PH_IGNORE: begin
        next_lk.phase = smcp_pkg::PH_IGNORE;
      end
      default: next_lk.phase = smcp_pkg::PH_IGNORE;
    endcase
  end

  // Link side state; a mode 3 idle rise may arrive
  // while deselected, so cs_n gates every update
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      lk <= '{seen_tgl: 1'b0, phase: smcp_pkg::PH_IGNORE, cnt: 3'h0,
             sh: 8'h00, tx: 8'h00, addr: 11'h000, wr_op: 1'b0,
             write_latch_flag: 1'b0, wr_armed: 1'b0, wp_sync: 2'h0};
    end else if (!cs_n) begin
      lk <= next_lk;
    end
  end

  // Nonvolatile storage: no reset on purpose
  always_ff @(posedge sck) begin
    if (mem_we) begin
      mem[lk.addr] <= byte_in;
    end
    if (nv_we) begin
      // Latch flag and fixed bits are not stored
      nv_bits <= {byte_in[smcp_pkg::ST_PIN_PROTECT],
                  byte_in[smcp_pkg::ST_BLOCK_HI],
                  byte_in[smcp_pkg::ST_BLOCK_LO]};
    end
  end

  // Output on falling edge; a stale frame never drives
  always_ff @(negedge sck or posedge cs_n or negedge nrst) begin
    if (!nrst) begin
      so_q <= 1'b0;
      so_en_q <= 1'b0;
    end else if (cs_n) begin
      so_q <= 1'b0;
      so_en_q <= 1'b0;
    end else begin
      so_q <= lk.tx[7];
      so_en_q <= ~new_tx & (lk.phase == smcp_pkg::PH_RDATA ||
                 (lk.phase == smcp_pkg::PH_STATUS && !lk.wr_op));
    end
  end

  assign so_o = so_q;
  assign so_oe_n = ~(so_en_q & ~cs_n);

  // System side: pin and status mirror, each bit an independent level
  always_comb begin
    next_sy = sy;
    next_sy.wp_sync = {sy.wp_sync[0], wp_n};
    next_sy.view_m = {nv_bits[2], 3'h0, nv_bits[1:0],
                      lk.write_latch_flag & ~lk.wr_armed, 1'b0};
    next_sy.view_s = sy.view_m;
    next_sy.busy_sync = {sy.busy_sync[0], ~cs_n};
    next_sy.mode_sync = {sy.mode_sync[0], mode3};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sy <= '0;
    end else if (ce) begin
      sy <= next_sy;
    end
  end

  assign status_view = sy.view_s;
  assign link_busy = sy.busy_sync[1];
  assign link_mode3 = sy.mode_sync[1];

  a_set_latch: assert property (@(posedge sck) disable iff (!nrst)
    (ph == smcp_pkg::PH_OPCODE && byte_done &&
     byte_in == smcp_pkg::OP_SET_LATCH) |=> (lk.write_latch_flag && !lk.wr_armed))
    else $error("set-latch op-code did not set the latch");

  a_clear_latch: assert property (@(posedge sck) disable iff (!nrst)
    (ph == smcp_pkg::PH_OPCODE && byte_done &&
     byte_in == smcp_pkg::OP_CLR_LATCH) |=> !lk.write_latch_flag)
    else $error("clear-latch op-code left the latch set");

  a_status_fixed: assert property (@(posedge sck) disable iff (!nrst)
    status_byte[6:4] == 3'h0 && !status_byte[0] &&
    status_byte[smcp_pkg::ST_LATCH] == wel_now)
    else $error("status byte layout broken");

  a_block_protect: assert property (@(posedge sck) disable iff (!nrst)
    mem_we |-> (nv_bits != 3'h3 && nv_bits[1:0] != smcp_pkg::BP_ALL &&
    !(nv_bits[1:0] == smcp_pkg::BP_HALF && lk.addr[10]) &&
    !(nv_bits[1:0] == smcp_pkg::BP_QUARTER && lk.addr[10:9] == 2'h3)))
    else $error("array write inside protected block");

  a_latch_needed: assert property (@(posedge sck) disable iff (!nrst)
    (mem_we || nv_we) |-> (wel_now && lk.write_latch_flag && lk.wr_armed))
    else $error("write accepted without latch");

  a_pin_protect: assert property (@(posedge sck) disable iff (!nrst)
    (nv_bits[2] && !lk.wp_sync[1]) |-> !nv_we)
    else $error("status written while pin protect active");

  a_addr_wrap: assert property (@(posedge sck) disable iff (!nrst)
    ((ph == smcp_pkg::PH_WDATA || ph == smcp_pkg::PH_RDATA) && byte_done &&
     lk.addr == smcp_pkg::ADDR_TOP) |=> lk.addr == 11'h000)
    else $error("address did not wrap to zero");

  a_one_opcode: assert property (@(posedge sck) disable iff (!nrst)
    (ph != smcp_pkg::PH_OPCODE) ##1 (lk.seen_tgl == cs_tgl) |->
    lk.phase != smcp_pkg::PH_OPCODE)
    else $error("second op-code taken in one frame");

  a_status_once: assert property (@(posedge sck) disable iff (!nrst)
    (ph == smcp_pkg::PH_STATUS && byte_done) |=>
    lk.phase == smcp_pkg::PH_IGNORE && lk.cnt == 3'h0)
    else $error("status phase longer than one byte");

  a_frame_start: assert property (@(posedge sck) disable iff (!nrst)
    new_tx |=> (lk.phase == smcp_pkg::PH_OPCODE && lk.cnt == 3'h1))
    else $error("frame did not start with an op-code byte");

  a_write_clears: assert property (@(posedge sck) disable iff (!nrst)
    (new_tx && lk.wr_armed) |=> !lk.write_latch_flag)
    else $error("latch survived the end of a write");

  a_keep_latch: assert property (@(posedge sck) disable iff (!nrst)
    nv_we |=> lk.write_latch_flag)
    else $error("status write changed the latch flag");

  a_ignore_holds: assert property (@(posedge sck) disable iff (!nrst)
    (lk.phase == smcp_pkg::PH_IGNORE && !new_tx) |->
    (!mem_we && !nv_we && next_lk.write_latch_flag == lk.write_latch_flag))
    else $error("ignored frame changed state");

  a_addr_hi: assert property (@(posedge sck) disable iff (!nrst)
    (ph == smcp_pkg::PH_ADDR_HI && byte_done) |=>
    lk.addr[10:8] == $past(byte_in[2:0]))
    else $error("upper address bits not taken");

  a_addr_step: assert property (@(posedge sck) disable iff (!nrst)
    (ph == smcp_pkg::PH_WDATA && byte_done) |=> lk.addr == $past(addr_inc))
    else $error("address did not advance after a write byte");

  a_pin_no_block: assert property (@(posedge sck) disable iff (!nrst)
    (ph == smcp_pkg::PH_WDATA && byte_done && wel_now && !addr_prot) |->
    mem_we)
    else $error("allowed array write was dropped");

  a_out_quiet: assert property (@(posedge sck) disable iff (!nrst)
    (lk.phase != smcp_pkg::PH_RDATA && lk.phase != smcp_pkg::PH_STATUS) |->
    so_oe_n)
    else $error("output driven outside a read");

  a_read_drive: assert property (@(posedge sck) disable iff (!nrst)
    (lk.phase == smcp_pkg::PH_RDATA && !new_tx && !cs_n) |-> !so_oe_n)
    else $error("read data not driven");

endmodule

// ===== verif/smcp_spi_master.sv
`timescale 1ns/1ps
module smcp_spi_master (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  logic m3 = 1'b0;
  initial sck = 1'b0;
  initial cs_n = 1'b1;
  initial si = 1'b0;
  task automatic start(input logic mode3);
    m3 = mode3;
    sck <= mode3;
    #40 cs_n <= 1'b0;
    #40;
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si <= d[i];
      #40 q[i] = so;
      sck <= 1'b1;
      #40;
    end
  endtask
  task automatic stop();
    sck <= m3;
    #40 cs_n <= 1'b1;
    // Idle data keeps moving so a stale level cannot pass
    si <= ~si;
    #40;
  endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce;
  logic wp_n;
  logic sck;
  logic cs_n;
  logic si;
  logic so_o;
  logic so_oe_n;
  logic [7:0] status_view;
  logic link_busy;
  logic link_mode3;
  wire so_line;
  int mismatches = 0;
  int samples_checked = 0;
  always #2.5 clk = ~clk;
  assign so_line = so_oe_n ? 1'bz : so_o;
  smcp_command_port dut (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .wp_n(wp_n),
    .so_o(so_o),
    .so_oe_n(so_oe_n),
    .status_view(status_view),
    .link_busy(link_busy),
    .link_mode3(link_mode3)
  );
  smcp_spi_master m (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    logic [7:0] x;
    m.start(1'b0);
    m.xb(op, x);
    m.stop();
  endtask
  task automatic stat(input logic [7:0] op, d, output logic [7:0] q);
    logic [7:0] x;
    m.start(1'b0);
    m.xb(op, x);
    m.xb(d, q);
    m.stop();
  endtask
  task automatic mem(input logic [7:0] op, input logic [15:0] a,
                     input logic [7:0] d0, d1);
    logic [7:0] x;
    m.start(1'b0);
    m.xb(op, x);
    m.xb(a[15:8], x);
    m.xb(a[7:0], x);
    m.xb(d0, x);
    m.xb(d1, x);
    m.stop();
  endtask
  task automatic rd2(input logic [15:0] a, input logic [7:0] e0, e1);
    logic [7:0] x;
    logic [7:0] q0;
    logic [7:0] q1;
    m.start(1'b0);
    m.xb(8'h03, x);
    m.xb(a[15:8], x);
    m.xb(a[7:0], x);
    m.xb(8'h00, q0);
    m.xb(8'h00, q1);
    m.stop();
    check(q0, e0);
    check(q1, e1);
  endtask
  task automatic wr2(input logic [15:0] a, input logic [7:0] d0, d1);
    cmd(8'h06);
    mem(8'h02, a, d0, d1);
  endtask
  task automatic rds(input logic [7:0] e);
    logic [7:0] q;
    stat(8'h05, 8'h00, q);
    check(q, e);
  endtask
  task automatic set_wp(input logic v);
    @(posedge clk) wp_n <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_reset();
    check({7'h0, so_oe_n}, 8'h01);
    rds(8'h00);
  endtask
  task automatic t_latch();
    cmd(8'h06);
    rds(8'h02);
    cmd(8'h04);
    rds(8'h00);
  endtask
  task automatic t_mem();
    wr2(16'hfdff, 8'ha5, 8'h3c);
    rd2(16'h05ff, 8'ha5, 8'h3c);
    rds(8'h00);
    mem(8'h02, 16'h05ff, 8'hff, 8'hff);
    rd2(16'h05ff, 8'ha5, 8'h3c);
    wr2(16'h07ff, 8'h11, 8'h22);
    rd2(16'h07ff, 8'h11, 8'h22);
  endtask
  task automatic t_prot();
    logic [7:0] q;
    cmd(8'h06);
    stat(8'h01, 8'hff, q);
    rds(8'h8c);
    repeat (8) @(posedge clk);
    check(status_view, 8'h8c);
    wr2(16'h07ff, 8'h77, 8'h77);
    rd2(16'h07ff, 8'h11, 8'h22);
    cmd(8'h06);
    stat(8'h01, 8'h84, q);
    rds(8'h84);
    set_wp(1'b0);
    cmd(8'h06);
    stat(8'h01, 8'h00, q);
    rds(8'h84);
    wr2(16'h05ff, 8'h5a, 8'h5b);
    rd2(16'h05ff, 8'h5a, 8'h3c);
    set_wp(1'b1);
    cmd(8'h06);
    stat(8'h01, 8'h00, q);
    rds(8'h00);
  endtask
  task automatic t_odd();
    logic [7:0] x;
    logic [7:0] q;
    m.start(1'b0);
    m.xb(8'hff, x);
    m.xb(8'h05, q);
    m.stop();
    check(q, 8'hzz);
    m.start(1'b0);
    m.xb(8'h06, x);
    m.xb(8'h05, x);
    m.xb(8'h00, q);
    m.stop();
    check(q, 8'hzz);
    rds(8'h02);
    cmd(8'h04);
  endtask
  task automatic t_mode3();
    logic [7:0] x;
    logic [7:0] q;
    m.start(1'b1);
    m.xb(8'h05, x);
    m.xb(8'h00, q);
    check({6'h0, link_busy, link_mode3}, 8'h03);
    m.stop();
    check(q, 8'h00);
    repeat (8) @(posedge clk);
    check({7'h0, link_busy}, 8'h00);
  endtask
  task automatic t_freeze();
    @(posedge clk) ce <= 1'b0;
    cmd(8'h06);
    repeat (8) @(posedge clk);
    check(status_view, 8'h00);
    @(posedge clk) ce <= 1'b1;
    repeat (8) @(posedge clk);
    check(status_view, 8'h02);
    check({7'h0, link_mode3}, 8'h00);
  endtask
  task automatic t_reset2();
    logic [7:0] q;
    stat(8'h01, 8'h08, q);
    cmd(8'h06);
    rds(8'h0a);
    @(posedge clk) nrst <= 1'b0;
    repeat (4) @(posedge clk);
    check({status_view[7:1], link_busy}, 8'h00);
    @(posedge clk) nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rds(8'h08);
    repeat (8) @(posedge clk);
    check(status_view, 8'h08);
  endtask
  initial begin
    // Covers the slowest run with a wide margin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    ce <= 1'b1;
    wp_n <= 1'b1;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_latch();
    t_mem();
    t_prot();
    t_odd();
    t_mode3();
    t_freeze();
    t_reset2();
    tally_and_finish();
  end
endmodule
